// ### design/iwt_consts.vh
// Constants for the interval and watchdog timer block.
`ifndef IWT_CONSTS_VH
`define IWT_CONSTS_VH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define IWT_IDX_INT_CTRL 8'h8B
`define IWT_IDX_INT_COUNT 8'h8C
`define IWT_IDX_WD_CTRL 8'h8D
`define IWT_IDX_WD_COUNT 8'h8E
`define IWT_IDX_IRQ_STATUS 8'h8F
`define IWT_IDX_IRQ_ENABLE 8'h90

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define IWT_PERIOD_SEL_RST 3'h1
`define IWT_WD_PERIOD_RST 8'hFF

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define IWT_INT_FLAG_BIT 7
`define IWT_INT_CLKSEL_HI 6
`define IWT_INT_CLKSEL_LO 5
`define IWT_INT_CLEAR_BIT 3
`define IWT_INT_PERSEL_HI 2
`define IWT_INT_PERSEL_LO 0
`define IWT_WD_EN_BIT 7
`define IWT_WD_RSTMODE_BIT 6
`define IWT_WD_CLEAR_BIT 5
`define IWT_WD_CLKSEL_BIT 1
`define IWT_WD_FLAG_BIT 0
`define IWT_IRQ_INT_BIT 0
`define IWT_IRQ_WD_BIT 1

// ----------------------------------------------------------------
// Prescaler widths and timing counts.
// ----------------------------------------------------------------
`define IWT_PRESCALE_W 12
`define IWT_DIV4096_BITS 12
`define IWT_DIV1024_BITS 10
`define IWT_DIV128_BITS 7
`define IWT_DIV16_BITS 4
`define IWT_CPU_RESET_CYCLES 5'h10

`endif

// ### design/iwt_prescaler.v
// System clock prescaler that yields the interval timer counting tick.
`timescale 1ns/10ps
`include "iwt_consts.vh"

module iwt_prescaler (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Control
    input wire [1:0] clock_select,
    input wire restart,
    // Tick out
    output reg tick
);

reg [`IWT_PRESCALE_W-1:0] divider;

// A tick is raised in the cycle after the one in which the selected low bits are all ones,
// so one tick lands every 4096, 1024, 128 or 16 system clocks.
function wraps;
    input [`IWT_PRESCALE_W-1:0] value;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: wraps = &value[`IWT_DIV4096_BITS-1:0];
            2'h1: wraps = &value[`IWT_DIV1024_BITS-1:0];
            2'h2: wraps = &value[`IWT_DIV128_BITS-1:0];
            default: wraps = &value[`IWT_DIV16_BITS-1:0];
        endcase
    end
endfunction

always @(posedge clock) begin
    if (rst || restart) begin
        divider <= 12'h000;
        tick <= 1'b0;
    end else begin
        divider <= divider + 12'h001;
        tick <= wraps(divider, clock_select);
    end
end

endmodule // iwt_prescaler

// ### design/iwt_timer.v
// Interval timer and watchdog with an Avalon-MM register slave.
`timescale 1ns/10ps
`include "iwt_consts.vh"

module iwt_timer (
    // System clock and reset
    input wire clock,
    input wire rst,
    // Avalon-MM register slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Interrupt acknowledge from the processor
    input wire interval_irq_ack,
    input wire watchdog_irq_ack,
    // Power management
    input wire stop_mode,
    output reg clocks_stable,
    // Dedicated low-frequency oscillator
    input wire watchdog_rc_clock,
    output reg watchdog_rc_enable,
    // Interrupt and reset requests
    output reg interval_irq_req,
    output reg watchdog_irq_req,
    output reg irq,
    output reg watchdog_cpu_reset
);

// ----------------------------------------------------------------
// State machine codes for oscillator stabilization.
// ----------------------------------------------------------------
localparam [2:0] ST_WAIT = 3'b001;
localparam [2:0] ST_RUN = 3'b010;
localparam [2:0] ST_STOP = 3'b100;

// ----------------------------------------------------------------
// Storage.
// ----------------------------------------------------------------
reg [7:0] interval_count;
reg [1:0] interval_clock_select;
reg [2:0] overflow_period_select;
reg interval_counter_clear;
reg interval_irq_flag;
reg watchdog_enable;
reg watchdog_reset_mode;
reg watchdog_counter_clear;
reg watchdog_clock_select;
reg watchdog_irq_flag;
reg [7:0] watchdog_count;
reg [7:0] watchdog_period;
reg [1:0] irq_enable;
reg [2:0] stab_state;
reg [2:0] next_stab_state;
reg rc_sync1;
reg rc_sync2;
reg rc_sync3;
reg rc_level;
reg [4:0] reset_hold;
reg [7:0] read_value;

wire int_tick;
wire int_overflow;
wire rc_rise;
wire wd_tick;
wire wd_match;
wire wr_commit;
wire [7:0] wdata;
wire wr_int_ctrl;
wire wr_wd_ctrl;
wire wr_wd_period;
wire wr_status;
wire wr_enable;
wire next_interval_flag;
wire next_watchdog_flag;

// ----------------------------------------------------------------
// Helper functions.
// ----------------------------------------------------------------

// Mask of counter bits 0..n; overflow is the carry out of bit n.
function [7:0] low_mask;
    input [2:0] n;
    begin
        case (n)
            3'h0: low_mask = 8'h01;
            3'h1: low_mask = 8'h03;
            3'h2: low_mask = 8'h07;
            3'h3: low_mask = 8'h0F;
            3'h4: low_mask = 8'h1F;
            3'h5: low_mask = 8'h3F;
            3'h6: low_mask = 8'h7F;
            default: low_mask = 8'hFF;
        endcase
    end
endfunction

function carry_out;
    input [7:0] value;
    input [2:0] n;
    begin
        carry_out = &(value | ~low_mask(n));
    end
endfunction

// Sticky flag: a set in the same cycle as a clear wins.
function flag_next;
    input current;
    input set;
    input clear;
    begin
        flag_next = set | (current & ~clear);
    end
endfunction

// ----------------------------------------------------------------
// Prescaler.
// ----------------------------------------------------------------
iwt_prescaler u_prescaler (
    .clock(clock),
    .rst(rst),
    .clock_select(interval_clock_select),
    .restart(stab_state == ST_STOP),
    .tick(int_tick)
);

// ----------------------------------------------------------------
// Register bus.
// ----------------------------------------------------------------

// Every access takes one wait state: the request is seen with
// waitrequest high, then waitrequest drops for exactly one cycle and
// the write commits on that edge. Reads are a snapshot of that first
// cycle, so a counter may have moved by one tick when it is seen.
assign wr_commit = avs_write && !avs_waitrequest && avs_byteenable[0];
assign wdata = avs_writedata[7:0];
assign wr_int_ctrl = wr_commit && (avs_address == `IWT_IDX_INT_CTRL);
assign wr_wd_ctrl = wr_commit && (avs_address == `IWT_IDX_WD_CTRL);
assign wr_wd_period = wr_commit && (avs_address == `IWT_IDX_WD_COUNT);
assign wr_status = wr_commit && (avs_address == `IWT_IDX_IRQ_STATUS);
assign wr_enable = wr_commit && (avs_address == `IWT_IDX_IRQ_ENABLE);

always @* begin
    case (avs_address)
        `IWT_IDX_INT_CTRL: read_value = {interval_irq_flag,
                                         interval_clock_select, 1'b0,
                                         interval_counter_clear,
                                         overflow_period_select};
        `IWT_IDX_INT_COUNT: read_value = interval_count;
        `IWT_IDX_WD_CTRL: read_value = {watchdog_enable, watchdog_reset_mode,
                                        watchdog_counter_clear, 3'h0,
                                        watchdog_clock_select,
                                        watchdog_irq_flag};
        `IWT_IDX_WD_COUNT: read_value = watchdog_count;
        `IWT_IDX_IRQ_STATUS: read_value = {6'h00, watchdog_irq_flag,
                                           interval_irq_flag};
        `IWT_IDX_IRQ_ENABLE: read_value = {6'h00, irq_enable};
        default: read_value = 8'h00;
    endcase
end

always @(posedge clock) begin
    if (rst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? {24'h000000, read_value} : 32'h00000000;
    end else begin
        avs_waitrequest <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Interval timer control.
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        interval_clock_select <= 2'h0;
        overflow_period_select <= `IWT_PERIOD_SEL_RST;
        interval_counter_clear <= 1'b0;
    end else if (wr_int_ctrl) begin
        interval_clock_select <= wdata[`IWT_INT_CLKSEL_HI:`IWT_INT_CLKSEL_LO];
        overflow_period_select <= wdata[`IWT_INT_PERSEL_HI:`IWT_INT_PERSEL_LO];
        interval_counter_clear <= wdata[`IWT_INT_CLEAR_BIT];
    end else begin
        interval_counter_clear <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Interval counter.
// ----------------------------------------------------------------

// Software has no way to halt the count; only a clear or the stop
// state holds it at zero, the latter so that the stabilization wait
// after leaving stop always runs a full overflow period.
always @(posedge clock) begin
    if (rst) begin
        interval_count <= 8'h00;
    end else if (interval_counter_clear || stab_state == ST_STOP) begin
        interval_count <= 8'h00;
    end else if (int_tick) begin
        interval_count <= interval_count + 8'h01;
    end
end

assign int_overflow = int_tick &&
    carry_out(interval_count, overflow_period_select);

assign next_interval_flag = flag_next(interval_irq_flag, int_overflow,
    (wr_int_ctrl && !wdata[`IWT_INT_FLAG_BIT]) || interval_irq_ack ||
    (wr_status && wdata[`IWT_IRQ_INT_BIT]));

always @(posedge clock) begin
    if (rst) begin
        interval_irq_flag <= 1'b0;
    end else begin
        interval_irq_flag <= next_interval_flag;
    end
end

// ----------------------------------------------------------------
// Oscillator stabilization.
// ----------------------------------------------------------------
always @* begin
    case (stab_state)
        ST_WAIT: next_stab_state = int_overflow ? ST_RUN : ST_WAIT;
        ST_RUN: next_stab_state = stop_mode ? ST_STOP : ST_RUN;
        ST_STOP: next_stab_state = stop_mode ? ST_STOP : ST_WAIT;
        default: next_stab_state = ST_WAIT;
    endcase
end

always @(posedge clock) begin
    if (rst) begin
        stab_state <= ST_WAIT;
        clocks_stable <= 1'b0;
    end else begin
        stab_state <= next_stab_state;
        clocks_stable <= (next_stab_state == ST_RUN);
    end
end

// ----------------------------------------------------------------
// RC oscillator input.
// ----------------------------------------------------------------

// The slow oscillator is asynchronous: three stages, and a level is
// accepted only once the last two agree, which filters a sample taken
// mid-transition. Its period is far longer than the system clock.
always @(posedge clock) begin
    if (rst) begin
        rc_sync1 <= 1'b0;
        rc_sync2 <= 1'b0;
        rc_sync3 <= 1'b0;
        rc_level <= 1'b0;
    end else begin
        rc_sync1 <= watchdog_rc_clock;
        rc_sync2 <= rc_sync1;
        rc_sync3 <= rc_sync2;
        if (rc_sync2 == rc_sync3) begin
            rc_level <= rc_sync3;
        end
    end
end

assign rc_rise = (rc_sync2 == rc_sync3) && rc_sync3 && !rc_level;

// ----------------------------------------------------------------
// Watchdog control.
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        watchdog_enable <= 1'b0;
        watchdog_reset_mode <= 1'b0;
        watchdog_counter_clear <= 1'b0;
        watchdog_clock_select <= 1'b0;
        watchdog_rc_enable <= 1'b0;
    end else begin
        if (wr_wd_ctrl) begin
            watchdog_enable <= wdata[`IWT_WD_EN_BIT];
            watchdog_reset_mode <= wdata[`IWT_WD_RSTMODE_BIT];
            watchdog_counter_clear <= wdata[`IWT_WD_CLEAR_BIT];
            watchdog_clock_select <= wdata[`IWT_WD_CLKSEL_BIT];
        end else begin
            watchdog_counter_clear <= 1'b0;
        end
        watchdog_rc_enable <= watchdog_clock_select;
    end
end

always @(posedge clock) begin
    if (rst) begin
        watchdog_period <= `IWT_WD_PERIOD_RST;
    end else if (wr_wd_period) begin
        watchdog_period <= wdata;
    end
end

// ----------------------------------------------------------------
// Watchdog counter.
// ----------------------------------------------------------------
assign wd_tick = watchdog_clock_select ? rc_rise : int_overflow;

// A period of zero matches on every tick; software must avoid it,
// the hardware simply keeps running in that case.
assign wd_match = watchdog_enable && wd_tick &&
    (watchdog_count == watchdog_period);

always @(posedge clock) begin
    if (rst) begin
        watchdog_count <= 8'h00;
    end else if (watchdog_counter_clear) begin
        watchdog_count <= 8'h00;
    end else if (wd_match) begin
        watchdog_count <= 8'h00;
    end else if (watchdog_enable && wd_tick) begin
        watchdog_count <= watchdog_count + 8'h01;
    end
end

assign next_watchdog_flag = flag_next(watchdog_irq_flag,
    wd_match && !watchdog_reset_mode,
    (wr_wd_ctrl && !wdata[`IWT_WD_FLAG_BIT]) || watchdog_irq_ack ||
    (wr_status && wdata[`IWT_IRQ_WD_BIT]));

always @(posedge clock) begin
    if (rst) begin
        watchdog_irq_flag <= 1'b0;
    end else begin
        watchdog_irq_flag <= next_watchdog_flag;
    end
end

// ----------------------------------------------------------------
// Processor reset request.
// ----------------------------------------------------------------

// The request is stretched to a fixed width so the system reset logic
// sees it even though this block is itself reset by it.
always @(posedge clock) begin
    if (rst) begin
        reset_hold <= 5'h00;
        watchdog_cpu_reset <= 1'b0;
    end else begin
        if (wd_match && watchdog_reset_mode) begin
            reset_hold <= `IWT_CPU_RESET_CYCLES;
        end else if (reset_hold != 5'h00) begin
            reset_hold <= reset_hold - 5'h01;
        end
        watchdog_cpu_reset <= (wd_match && watchdog_reset_mode) ||
            (reset_hold > 5'h01);
    end
end

// ----------------------------------------------------------------
// Interrupt enables and outputs.
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        irq_enable <= 2'h0;
    end else if (wr_enable) begin
        irq_enable <= wdata[1:0];
    end
end

always @(posedge clock) begin
    if (rst) begin
        interval_irq_req <= 1'b0;
        watchdog_irq_req <= 1'b0;
        irq <= 1'b0;
    end else begin
        interval_irq_req <= interval_irq_flag && irq_enable[`IWT_IRQ_INT_BIT];
        watchdog_irq_req <= watchdog_irq_flag && irq_enable[`IWT_IRQ_WD_BIT];
        irq <= (interval_irq_flag && irq_enable[`IWT_IRQ_INT_BIT]) ||
            (watchdog_irq_flag && irq_enable[`IWT_IRQ_WD_BIT]);
    end
end

endmodule // iwt_timer

// ### sim/iwt_partner.sv
// Processor-side model: interrupt acknowledge and the slow watchdog oscillator.
`timescale 1ns/10ps
module iwt_partner (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Bench control
    input wire ack_on,
    // Device side
    input wire interval_irq_req,
    input wire watchdog_irq_req,
    input wire watchdog_rc_enable,
    output reg interval_irq_ack,
    output reg watchdog_irq_ack,
    output reg watchdog_rc_clock
);
    reg [1:0] busy;
    wire [1:0] req;
    assign req = {watchdog_irq_req, interval_irq_req};

    // One pulse per request; busy stops a second pulse while the request drains.
    always @(posedge clock) begin
        if (rst) begin
            busy <= 2'h0;
            {watchdog_irq_ack, interval_irq_ack} <= 2'h0;
        end else begin
            {watchdog_irq_ack, interval_irq_ack} <= req & ~busy & {2{ack_on}};
            busy <= req & (busy | {2{ack_on}});
        end
    end

    // The oscillator is off while disabled, so its output stands low.
    initial begin
        watchdog_rc_clock = 1'h0;
        forever begin
            #125.15;
            watchdog_rc_clock = watchdog_rc_enable ? ~watchdog_rc_clock : 1'h0;
        end
    end
endmodule // iwt_partner

// ### sim/iwt_timer_asserts.sv
// Concurrent checks on the ports of the interval and watchdog timer.
`timescale 1ns/10ps
module iwt_timer_asserts (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register bus
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Interrupts and reset request
    input wire interval_irq_ack,
    input wire watchdog_irq_ack,
    input wire interval_irq_req,
    input wire watchdog_irq_req,
    input wire irq,
    input wire watchdog_cpu_reset,
    // Power management
    input wire stop_mode,
    input wire clocks_stable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    // Counting the pulse keeps the width check free of long repetitions.
    reg [4:0] reset_len;
    always @(posedge clock) begin
        if (rst || !watchdog_cpu_reset) begin
            reset_len <= 5'h0;
        end else begin
            reset_len <= reset_len + 5'h1;
        end
    end

    sequence s_request;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_bus_access: assert property (s_request |=> s_answer)
        else $error("bus access not answered in one cycle");
    a_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    a_readdata_upper: assert property (avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_irq_merge: assert property (irq == (interval_irq_req || watchdog_irq_req))
        else $error("irq differs from the request merge");
    a_int_release: assert property ($fell(interval_irq_req) |->
        $past(interval_irq_ack, 2) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("interval request fell without ack or write");
    a_wd_release: assert property ($fell(watchdog_irq_req) |->
        $past(watchdog_irq_ack, 2) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("watchdog request fell without ack or write");
    a_reset_width: assert property ($fell(watchdog_cpu_reset) |-> reset_len == 5'h10)
        else $error("processor reset pulse width wrong");
    a_reset_bound: assert property (reset_len <= 5'h10)
        else $error("processor reset pulse too long");
    a_stop_wait: assert property (stop_mode ##1 stop_mode |-> !clocks_stable)
        else $error("clocks reported stable during stop");
endmodule // iwt_timer_asserts

bind iwt_timer iwt_timer_asserts u_asserts (
    .clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .interval_irq_ack(interval_irq_ack), .watchdog_irq_ack(watchdog_irq_ack),
    .interval_irq_req(interval_irq_req), .watchdog_irq_req(watchdog_irq_req), .irq(irq),
    .watchdog_cpu_reset(watchdog_cpu_reset), .stop_mode(stop_mode),
    .clocks_stable(clocks_stable)
);

// ### sim/test_iwt_timer.sv
// Self-checking testbench for the interval and watchdog timer.
`timescale 1ns/10ps
`include "iwt_consts.vh"
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module test_iwt_timer;
    logic clock, rst, avs_read, avs_write, stop_mode, ack_on;
    logic [7:0] avs_address, q, c1;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, interval_irq_ack, watchdog_irq_ack, clocks_stable;
    wire watchdog_rc_clock, watchdog_rc_enable, interval_irq_req, watchdog_irq_req;
    wire irq, watchdog_cpu_reset;
    wire [2:0] evt;
    int err_count, total_checks, cyc, t0, t1, i;
    int divs[4] = '{4096, 1024, 128, 16};
    assign evt = {watchdog_cpu_reset, watchdog_irq_req, interval_irq_req};

    iwt_timer u_dut (
        .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .interval_irq_ack(interval_irq_ack),
        .watchdog_irq_ack(watchdog_irq_ack), .stop_mode(stop_mode),
        .clocks_stable(clocks_stable), .watchdog_rc_clock(watchdog_rc_clock),
        .watchdog_rc_enable(watchdog_rc_enable), .interval_irq_req(interval_irq_req),
        .watchdog_irq_req(watchdog_irq_req), .irq(irq), .watchdog_cpu_reset(watchdog_cpu_reset)
    );
    iwt_partner u_partner (
        .clock(clock), .rst(rst), .ack_on(ack_on), .interval_irq_req(interval_irq_req),
        .watchdog_irq_req(watchdog_irq_req), .watchdog_rc_enable(watchdog_rc_enable),
        .interval_irq_ack(interval_irq_ack), .watchdog_irq_ack(watchdog_irq_ack),
        .watchdog_rc_clock(watchdog_rc_clock)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] rdata);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        // Only the bench watchdog ends a wait for the answer.
        do @(posedge clock); while (avs_waitrequest !== 1'h0);
        rdata = avs_readdata[7:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'h1, a, d, 4'hF, x);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] rdata);
        bus(1'h0, a, 8'h00, 4'hF, rdata);
    endtask

    // Waits for a fresh rising edge of one event, so a level left high is not counted.
    task automatic wait_rise(input int which, output int t);
        int n;
        logic seen_low;
        seen_low = 1'h0;
        for (n = 0; n < 10000; n++) begin
            @(posedge clock);
            if (evt[which] !== 1'h1) seen_low = 1'h1;
            else if (seen_low) break;
        end
        if (n == 10000) err_count++;
        t = cyc;
    endtask

    task done(input string name);
        $display("test %s finished, mismatches %0d", name, err_count);
    endtask

    task finish_test;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        finish_test();
    end

    initial begin
        cyc = 0;
        rst = 1'h1;
        {avs_read, avs_write, stop_mode} = 3'h0;
        ack_on = 1'h1;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        rd_reg(`IWT_IDX_INT_CTRL, q); `CHK(q, 8'h01)
        rd_reg(`IWT_IDX_WD_CTRL, q); `CHK(q, 8'h00)
        rd_reg(`IWT_IDX_WD_COUNT, q); `CHK(q, 8'h00)
        wr_reg(`IWT_IDX_INT_COUNT, 8'h55);
        rd_reg(`IWT_IDX_INT_COUNT, q); `CHK(q, 8'h00)
        wr_reg(8'h10, 8'hA5);
        rd_reg(8'h10, q); `CHK(q, 8'h00)
        bus(1'h1, `IWT_IDX_IRQ_ENABLE, 8'h03, 4'h0, q);
        rd_reg(`IWT_IDX_IRQ_ENABLE, q); `CHK(q, 8'h00)
        done("reset values");

        // The read gap is fixed so the tick count over it is exact.
        for (i = 0; i < 4; i++) begin
            wr_reg(`IWT_IDX_INT_CTRL, {1'h0, i[1:0], 5'h08});
            rd_reg(`IWT_IDX_INT_CTRL, q); `CHK(q & 8'h7F, {1'h0, i[1:0], 5'h00})
            rd_reg(`IWT_IDX_INT_COUNT, c1); `CHK(c1 <= 8'h01, 1'h1)
            repeat (2 * divs[i] - 3) @(posedge clock);
            rd_reg(`IWT_IDX_INT_COUNT, q); `CHK(q - c1, 8'h02)
        end
        done("clock select");

        wr_reg(`IWT_IDX_IRQ_ENABLE, 8'h01);
        for (i = 0; i < 8; i++) begin
            wr_reg(`IWT_IDX_INT_CTRL, {5'h0C, i[2:0]});
            wait_rise(0, t0);
            wait_rise(0, t0);
            wait_rise(0, t1);
            `CHK(irq, 1'h1)
            `CHK(t1 - t0, 16 << (i + 1))
        end
        wr_reg(`IWT_IDX_IRQ_ENABLE, 8'h00);
        repeat (4200) @(posedge clock);
        `CHK(irq, 1'h0)
        rd_reg(`IWT_IDX_IRQ_STATUS, q); `CHK(q[0], 1'h1)
        wr_reg(`IWT_IDX_IRQ_STATUS, 8'h01);
        rd_reg(`IWT_IDX_INT_CTRL, q); `CHK(q, 8'h67)
        repeat (4200) @(posedge clock);
        wr_reg(`IWT_IDX_INT_CTRL, 8'h67);
        rd_reg(`IWT_IDX_INT_CTRL, q); `CHK(q[7], 1'h0)
        done("interval overflow");

        wr_reg(`IWT_IDX_INT_CTRL, 8'h60);
        wr_reg(`IWT_IDX_WD_COUNT, 8'h03);
        wr_reg(`IWT_IDX_IRQ_ENABLE, 8'h02);
        wr_reg(`IWT_IDX_WD_CTRL, 8'hA0);
        rd_reg(`IWT_IDX_WD_COUNT, q); `CHK(q <= 8'h01, 1'h1)
        rd_reg(`IWT_IDX_WD_CTRL, q); `CHK(q & 8'hFE, 8'h80)
        wait_rise(1, t0);
        wait_rise(1, t0);
        wait_rise(1, t1);
        `CHK(t1 - t0, 32 * 4)
        `CHK(watchdog_cpu_reset, 1'h0)
        wr_reg(`IWT_IDX_WD_CTRL, 8'hE0);
        wait_rise(2, t0);
        wait_rise(2, t1);
        `CHK(t1 - t0, 32 * 4)
        `CHK(watchdog_irq_req, 1'h0)
        wr_reg(`IWT_IDX_WD_CTRL, 8'h00);
        rd_reg(`IWT_IDX_WD_COUNT, c1);
        repeat (200) @(posedge clock);
        rd_reg(`IWT_IDX_WD_COUNT, q); `CHK(q, c1)
        done("watchdog");

        // Slow oscillator period is near 50 clocks, well apart from the 32-clock overflow.
        wr_reg(`IWT_IDX_WD_COUNT, 8'hFF);
        wr_reg(`IWT_IDX_WD_CTRL, 8'hA2);
        repeat (2) @(posedge clock);
        `CHK(watchdog_rc_enable, 1'h1)
        rd_reg(`IWT_IDX_WD_COUNT, c1);
        repeat (497) @(posedge clock);
        rd_reg(`IWT_IDX_WD_COUNT, q); `CHK((q - c1 >= 8'h09) && (q - c1 <= 8'h0B), 1'h1)
        wr_reg(`IWT_IDX_WD_CTRL, 8'h00);
        repeat (2) @(posedge clock);
        `CHK(watchdog_rc_enable, 1'h0)
        done("slow oscillator");

        stop_mode <= 1'h1;
        repeat (10) @(posedge clock);
        `CHK(clocks_stable, 1'h0)
        stop_mode <= 1'h0;
        repeat (3) @(posedge clock);
        `CHK(clocks_stable, 1'h0)
        for (i = 0; i < 200; i++) begin
            @(posedge clock);
            if (clocks_stable === 1'h1) break;
        end
        `CHK(clocks_stable, 1'h1)
        done("stop mode");
        finish_test();
    end
endmodule // test_iwt_timer
